// file: inc/rdtc_cfg.svh
// Register indices, reset values and scaling constants of the roll calculator.
`ifndef RDTC_CFG_SVH
`define RDTC_CFG_SVH
`define RDTC_DW 16
`define RDTC_IDX_W 8
`define RDTC_IDX_LSB 2
`define RDTC_IDX_MSB 9
`define RDTC_IDX_LINE 8'hDE
`define RDTC_IDX_KIND 8'hE2
`define RDTC_IDX_METHOD 8'hE3
`define RDTC_IDX_CORE 8'hE4
`define RDTC_IDX_FULL 8'hE5
`define RDTC_IDX_TURNS 8'hE6
`define RDTC_IDX_LEN 8'hE7
`define RDTC_IDX_RATIO 8'hE8
`define RDTC_IDX_REEL 8'hE9
`define RDTC_IDX_FREEZE 8'hEA
`define RDTC_IDX_THRESH 8'hEB
`define RDTC_IDX_SMOOTH 8'hEC
`define RDTC_IDX_PICK_HI 8'hED
`define RDTC_IDX_PICK_LO 8'hEE
`define RDTC_IDX_GAUGE0 8'hEF
`define RDTC_IDX_GAUGE1 8'hF0
`define RDTC_IDX_GAUGE2 8'hF1
`define RDTC_IDX_GAUGE3 8'hF2
`define RDTC_IDX_CORE_RATIO 8'hF3
`define RDTC_IDX_FULL_RATIO 8'hF4
`define RDTC_IDX_SIZE 8'hF5
`define RDTC_IDX_SETPOINT 8'hF6
`define RDTC_IDX_TAPER_START 8'hF7
`define RDTC_IDX_TAPER 8'hF8
`define RDTC_IDX_DEMAND 8'hF9
`define RDTC_HSIZE_WORD 3'h2
`define RDTC_RST_CORE 16'h0064
`define RDTC_RST_FULL 16'h03E8
`define RDTC_RST_LEN 16'h0001
`define RDTC_RST_THRESH 16'h00C8
`define RDTC_RST_TAPER_START 16'h0064
`define RDTC_RST_CORE_RATIO 16'h2710
`define RDTC_RST_FULL_RATIO 16'h03E8
`define RDTC_FULL_SCALE 16'h2710
`define RDTC_METHOD_MAX 16'h0004
`define RDTC_TURN_MUL 16'h0002
`define RDTC_GAUGE_DIV 16'h000A
`define RDTC_PI_NUM 16'h01C4
`define RDTC_PI_DEN 16'h8AAC
`define RDTC_SMOOTH_MAX 4'hF
`define RDTC_FRAC 16
`define RDTC_DIV_NW 64
`define RDTC_DIV_DW 40
`endif

// file: inc/rdtc_pkg.sv
// Types shared by the roll diameter and taper calculator.
`include "rdtc_cfg.svh"
package rdtc_pkg;
	typedef logic [`RDTC_DW-1:0] rdtc_word_t;
	typedef enum logic [2:0] {
		RDTC_M_OFF,
		RDTC_M_EXT,
		RDTC_M_ROLL,
		RDTC_M_LINE,
		RDTC_M_SPEED
	} rdtc_method_t;
	typedef enum {
		ST_RAW_GO, ST_RAW_WAIT, ST_FILT,
		ST_CORE_GO, ST_CORE_WAIT, ST_FULL_GO, ST_FULL_WAIT,
		ST_TAPER_GO, ST_TAPER_WAIT
	} rdtc_state_t;
	typedef struct packed {
		rdtc_word_t line;
		rdtc_word_t kind;
		rdtc_word_t method;
		rdtc_word_t core;
		rdtc_word_t full;
		rdtc_word_t turns;
		rdtc_word_t len;
		rdtc_word_t ratio;
		rdtc_word_t reel;
		rdtc_word_t freeze;
		rdtc_word_t thresh;
		rdtc_word_t smooth;
		rdtc_word_t pick_hi;
		rdtc_word_t pick_lo;
		logic [3:0][`RDTC_DW-1:0] gauge;
		rdtc_word_t setpoint;
		rdtc_word_t taper_start;
		rdtc_word_t taper;
	} rdtc_setup_t;
	typedef struct packed {
		rdtc_word_t size;
		rdtc_word_t core_ratio;
		rdtc_word_t full_ratio;
		rdtc_word_t demand;
	} rdtc_result_t;
endpackage : rdtc_pkg

// file: logic/rdtc_divider.sv
// Restoring serial divider with a quotient that saturates.
`timescale 1ns/1ps
module rdtc_divider #(
	parameter int NW = 64,
	parameter int DW = 40,
	parameter int QW = 16
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic srst,
	// Request.
	input wire logic start,
	input wire logic [NW-1:0] numer,
	input wire logic [DW-1:0] denom,
	// Answer.
	output logic done,
	output logic [QW-1:0] quot
);
	localparam int CW = $clog2(NW + 1);
	logic [NW-1:0] n;
	logic [DW-1:0] d;
	logic [DW:0] r;
	logic [DW:0] trial;
	logic [CW-1:0] cnt;
	logic busy;

	always_comb begin
		trial = {r[DW-1:0], n[NW-1]};
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			n <= '0;
			d <= '0;
			r <= '0;
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				n <= numer;
				d <= denom;
				r <= '0;
				cnt <= CW'(NW);
				busy <= 1'b1;
			end else if (busy) begin
				if (trial >= {1'b0, d}) begin
					r <= trial - {1'b0, d};
					n <= {n[NW-2:0], 1'b1};
				end else begin
					r <= trial;
					n <= {n[NW-2:0], 1'b0};
				end
				cnt <= cnt - 1'b1;
				if (cnt == CW'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

	// A zero divisor or an oversized quotient reads as full scale.
	assign quot = (d == '0 || |n[NW-1:QW]) ? '1 : n[QW-1:0];
endmodule : rdtc_divider

// file: logic/rdtc_top.sv
// Roll diameter calculator with taper tension, reached over AHB-Lite.
// How it works
// - method zero shows core diameter
// - method one maps external ratio
// - method two counts roll turns
// - method three uses line length turns
// - method four divides line by roll speed
// - roll kind picks winder or unwinder in methods two and three
// - freeze holds diameter in method four
// - low line speed without freeze forces core diameter in method four
// - averaging filter, larger setting smooths more
// - two bits choose one of four gauges
// - core ratio is core over diameter
// - full ratio is diameter over maximum
// - taper cuts demand above start diameter
// - full roll cut equals taper times setpoint
// - demand equals setpoint below taper start
`timescale 1ns/1ps
`include "rdtc_cfg.svh"
module rdtc_top
	import rdtc_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic srst,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Results for the roll speed and tension stages.
	output rdtc_result_t calc_out
);
	localparam int NW = `RDTC_DIV_NW;
	localparam int DW = `RDTC_DIV_DW;
	localparam int W = `RDTC_DW;
	localparam int F = `RDTC_FRAC;

	rdtc_setup_t s;
	rdtc_state_t state;
	rdtc_method_t mth;
	logic accept;
	logic wr_pend;
	logic rd_pend;
	logic map_q;
	logic [`RDTC_IDX_W-1:0] idx_q;
	logic [W-1:0] wd;
	logic [W-1:0] rd_val;
	logic [W-1:0] gauge;
	logic [31:0] line_len;
	logic [W-1:0] span;
	logic [W-1:0] size;
	logic [W-1:0] top;
	logic [W-1:0] cut;
	logic [16:0] raw;
	logic [16:0] raw_q;
	logic [16:0] clamped;
	logic direct;
	logic freeze;
	logic standstill;
	logic flat;
	logic [3:0] k;
	logic [31:0] acc;
	logic signed [32:0] diff;
	logic signed [32:0] step;
	logic div_go;
	logic div_done;
	logic [NW-1:0] div_num;
	logic [DW-1:0] div_den;
	logic [W-1:0] div_q;

	////////////////////////////////////////////////////////////////////////
	// Bus slave.

	assign accept = hsel & htrans[1] & hready;
	assign wd = hwdata[W-1:0];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			idx_q <= '0;
			map_q <= 1'b0;
		end else begin
			wr_pend <= accept & hwrite & (hsize == `RDTC_HSIZE_WORD);
			rd_pend <= accept & ~hwrite;
			if (accept) begin
				idx_q <= haddr[`RDTC_IDX_MSB:`RDTC_IDX_LSB];
				map_q <= (haddr[31:`RDTC_IDX_MSB+1] == '0) &&
					(haddr[`RDTC_IDX_LSB-1:0] == '0);
			end
		end
	end

	// Reads take one wait state so a write just before is seen.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			hreadyout <= 1'b1;
			hrdata <= '0;
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
			if (rd_pend) begin
				hrdata <= {{(32 - W){1'b0}}, rd_val};
				hreadyout <= 1'b1;
			end else if (accept && !hwrite) begin
				hreadyout <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_val = '0;
		if (map_q) begin
			case (idx_q)
				`RDTC_IDX_LINE: rd_val = s.line;
				`RDTC_IDX_KIND: rd_val = s.kind;
				`RDTC_IDX_METHOD: rd_val = s.method;
				`RDTC_IDX_CORE: rd_val = s.core;
				`RDTC_IDX_FULL: rd_val = s.full;
				`RDTC_IDX_TURNS: rd_val = s.turns;
				`RDTC_IDX_LEN: rd_val = s.len;
				`RDTC_IDX_RATIO: rd_val = s.ratio;
				`RDTC_IDX_REEL: rd_val = s.reel;
				`RDTC_IDX_FREEZE: rd_val = s.freeze;
				`RDTC_IDX_THRESH: rd_val = s.thresh;
				`RDTC_IDX_SMOOTH: rd_val = s.smooth;
				`RDTC_IDX_PICK_HI: rd_val = s.pick_hi;
				`RDTC_IDX_PICK_LO: rd_val = s.pick_lo;
				`RDTC_IDX_GAUGE0: rd_val = s.gauge[0];
				`RDTC_IDX_GAUGE1: rd_val = s.gauge[1];
				`RDTC_IDX_GAUGE2: rd_val = s.gauge[2];
				`RDTC_IDX_GAUGE3: rd_val = s.gauge[3];
				`RDTC_IDX_CORE_RATIO: rd_val = calc_out.core_ratio;
				`RDTC_IDX_FULL_RATIO: rd_val = calc_out.full_ratio;
				`RDTC_IDX_SIZE: rd_val = calc_out.size;
				`RDTC_IDX_SETPOINT: rd_val = s.setpoint;
				`RDTC_IDX_TAPER_START: rd_val = s.taper_start;
				`RDTC_IDX_TAPER: rd_val = s.taper;
				`RDTC_IDX_DEMAND: rd_val = calc_out.demand;
				default: rd_val = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s <= '0;
			s.core <= `RDTC_RST_CORE;
			s.full <= `RDTC_RST_FULL;
			s.len <= `RDTC_RST_LEN;
			s.thresh <= `RDTC_RST_THRESH;
			s.taper_start <= `RDTC_RST_TAPER_START;
		end else if (wr_pend && map_q) begin
			case (idx_q)
				`RDTC_IDX_LINE: s.line <= wd;
				`RDTC_IDX_KIND: s.kind <= wd;
				`RDTC_IDX_METHOD: s.method <= wd;
				`RDTC_IDX_CORE: s.core <= wd;
				`RDTC_IDX_FULL: s.full <= wd;
				`RDTC_IDX_TURNS: s.turns <= wd;
				`RDTC_IDX_LEN: s.len <= wd;
				`RDTC_IDX_RATIO: s.ratio <= wd;
				`RDTC_IDX_REEL: s.reel <= wd;
				`RDTC_IDX_FREEZE: s.freeze <= wd;
				`RDTC_IDX_THRESH: s.thresh <= wd;
				`RDTC_IDX_SMOOTH: s.smooth <= wd;
				`RDTC_IDX_PICK_HI: s.pick_hi <= wd;
				`RDTC_IDX_PICK_LO: s.pick_lo <= wd;
				`RDTC_IDX_GAUGE0: s.gauge[0] <= wd;
				`RDTC_IDX_GAUGE1: s.gauge[1] <= wd;
				`RDTC_IDX_GAUGE2: s.gauge[2] <= wd;
				`RDTC_IDX_GAUGE3: s.gauge[3] <= wd;
				`RDTC_IDX_SETPOINT: s.setpoint <= wd;
				`RDTC_IDX_TAPER_START: s.taper_start <= wd;
				`RDTC_IDX_TAPER: s.taper <= wd;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Operands.

	// Method codes above the last one behave as no calculation.
	always_comb begin
		if (s.method > `RDTC_METHOD_MAX) begin
			mth = RDTC_M_OFF;
		end else begin
			mth = rdtc_method_t'(s.method[2:0]);
		end
	end

	assign gauge = s.gauge[{s.pick_hi[0], s.pick_lo[0]}];
	assign line_len = s.turns * s.len;
	assign span = (s.full > s.core) ? s.full - s.core : '0;
	assign freeze = |s.freeze;
	assign standstill = s.line < s.thresh;
	assign size = acc[31:F];
	assign top = (size > s.full) ? s.full : size;
	assign flat = size <= s.taper_start;
	assign cut = (div_q > s.setpoint) ? s.setpoint : div_q;

	always_comb begin
		div_go = 1'b0;
		div_num = '0;
		div_den = '0;
		case (state)
			ST_RAW_GO: begin
				case (mth)
					RDTC_M_EXT: begin
						div_go = 1'b1;
						div_num = NW'(s.ratio) * NW'(span);
						div_den = DW'(`RDTC_FULL_SCALE);
					end
					RDTC_M_ROLL: begin
						div_go = 1'b1;
						div_num = NW'(`RDTC_TURN_MUL) * NW'(gauge) *
							NW'(s.turns);
						div_den = DW'(`RDTC_GAUGE_DIV);
					end
					RDTC_M_LINE: begin
						// Turns are length over the mean wound circumference.
						div_go = 1'b1;
						div_num = NW'(`RDTC_PI_NUM) * NW'(gauge) *
							NW'(line_len);
						div_den = DW'(`RDTC_PI_DEN) * (DW'(size) + DW'(s.core));
					end
					RDTC_M_SPEED: begin
						div_go = !freeze && !standstill;
						div_num = NW'(s.core) * NW'(s.line);
						div_den = DW'(s.reel);
					end
					default: ;
				endcase
			end
			ST_CORE_GO: begin
				div_go = 1'b1;
				div_num = NW'(s.core) * NW'(`RDTC_FULL_SCALE);
				div_den = DW'(size);
			end
			ST_FULL_GO: begin
				div_go = 1'b1;
				div_num = NW'(size) * NW'(`RDTC_FULL_SCALE);
				div_den = DW'(s.full);
			end
			ST_TAPER_GO: begin
				div_go = !flat;
				if (s.full > s.taper_start) begin
					div_num = NW'(s.setpoint) * NW'(s.taper) *
						NW'(top - s.taper_start);
					div_den = DW'(`RDTC_FULL_SCALE) *
						DW'(s.full - s.taper_start);
				end else begin
					div_num = NW'(s.setpoint) * NW'(s.taper);
					div_den = DW'(`RDTC_FULL_SCALE);
				end
			end
			default: ;
		endcase
	end

	rdtc_divider #(
		.NW(NW),
		.DW(DW),
		.QW(W)
	) u_div (
		.ref_clk(ref_clk),
		.srst(srst),
		.start(div_go),
		.numer(div_num),
		.denom(div_den),
		.done(div_done),
		.quot(div_q)
	);

	always_comb begin
		case (mth)
			RDTC_M_EXT: raw_q = {1'b0, s.core} + {1'b0, div_q};
			RDTC_M_ROLL, RDTC_M_LINE: begin
				if (!s.kind[0]) begin
					raw_q = {1'b0, s.core} + {1'b0, div_q};
				end else if (s.full > div_q) begin
					raw_q = {1'b0, s.full - div_q};
				end else begin
					raw_q = '0;
				end
			end
			default: raw_q = {1'b0, div_q};
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer.

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= ST_RAW_GO;
			raw <= '0;
			direct <= 1'b0;
		end else begin
			case (state)
				ST_RAW_GO: begin
					direct <= 1'b1;
					state <= ST_FILT;
					if (mth == RDTC_M_OFF) begin
						raw <= {1'b0, s.core};
					end else if (mth == RDTC_M_SPEED && freeze) begin
						raw <= {1'b0, size};
					end else if (mth == RDTC_M_SPEED && standstill) begin
						raw <= {1'b0, s.core};
					end else begin
						direct <= 1'b0;
						state <= ST_RAW_WAIT;
					end
				end
				ST_RAW_WAIT: begin
					if (div_done) begin
						raw <= raw_q;
						state <= ST_FILT;
					end
				end
				ST_FILT: state <= ST_CORE_GO;
				ST_CORE_GO: state <= ST_CORE_WAIT;
				ST_CORE_WAIT: state <= div_done ? ST_FULL_GO : ST_CORE_WAIT;
				ST_FULL_GO: state <= ST_FULL_WAIT;
				ST_FULL_WAIT: state <= div_done ? ST_TAPER_GO : ST_FULL_WAIT;
				ST_TAPER_GO: state <= flat ? ST_RAW_GO : ST_TAPER_WAIT;
				ST_TAPER_WAIT: state <= div_done ? ST_RAW_GO : ST_TAPER_WAIT;
				default: state <= ST_RAW_GO;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Averaging filter on the diameter.

	always_comb begin
		if (raw < {1'b0, s.core}) begin
			clamped = {1'b0, s.core};
		end else if (raw > {1'b0, s.full}) begin
			clamped = {1'b0, s.full};
		end else begin
			clamped = raw;
		end
	end

	assign k = (s.smooth > W'(`RDTC_SMOOTH_MAX)) ? `RDTC_SMOOTH_MAX :
		s.smooth[3:0];
	assign diff = $signed({1'b0, clamped[W-1:0], F'(0)}) - $signed({1'b0, acc});
	assign step = diff >>> k;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			acc <= {`RDTC_RST_CORE, F'(0)};
		end else if (state == ST_FILT) begin
			if (direct) begin
				acc <= {clamped[W-1:0], F'(0)};
			end else begin
				acc <= acc + step[31:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			calc_out.size <= `RDTC_RST_CORE;
			calc_out.core_ratio <= `RDTC_RST_CORE_RATIO;
			calc_out.full_ratio <= `RDTC_RST_FULL_RATIO;
			calc_out.demand <= '0;
		end else begin
			if (state == ST_CORE_GO) begin
				calc_out.size <= size;
			end
			if (state == ST_CORE_WAIT && div_done) begin
				calc_out.core_ratio <= div_q;
			end
			if (state == ST_FULL_WAIT && div_done) begin
				calc_out.full_ratio <= div_q;
			end
			if (state == ST_TAPER_GO && flat) begin
				calc_out.demand <= s.setpoint;
			end
			if (state == ST_TAPER_WAIT && div_done) begin
				calc_out.demand <= s.setpoint - cut;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence s_read_wait;
		!hreadyout ##1 hreadyout;
	endsequence

	a_off_core:
	assert property (state == ST_RAW_GO && mth == RDTC_M_OFF |-> ##2
		size == $past(s.core, 2)) else $error("core not shown when off");
	a_freeze_keeps:
	assert property (state == ST_RAW_GO && mth == RDTC_M_SPEED && freeze
		|-> ##2 size == $past(size, 2)) else $error("freeze lost diameter");
	a_standstill_core:
	assert property (state == ST_RAW_GO && mth == RDTC_M_SPEED && !freeze &&
		standstill |-> ##2 size == $past(s.core, 2))
		else $error("standstill did not force core");
	a_smooth_none:
	assert property (state == ST_FILT && !direct && k == 4'h0 |=>
		size == $past(clamped[W-1:0])) else $error("unfiltered value wrong");
	a_core_ratio:
	assert property (state == ST_CORE_WAIT && div_done |=>
		calc_out.core_ratio == $past(div_q)) else $error("core ratio stale");
	a_full_ratio:
	assert property (state == ST_FULL_WAIT && div_done |=>
		calc_out.full_ratio == $past(div_q)) else $error("full ratio stale");
	a_flat_demand:
	assert property (state == ST_TAPER_GO && flat |=>
		calc_out.demand == $past(s.setpoint)) else $error("demand not flat");
	a_taper_cut:
	assert property (state == ST_TAPER_WAIT && div_done |=>
		calc_out.demand == $past(s.setpoint) - $past(cut) &&
		calc_out.demand <= $past(s.setpoint)) else $error("taper cut wrong");
	a_read_wait:
	assert property (accept && !hwrite |=> s_read_wait)
		else $error("read wait state wrong");
	a_loop_bound:
	assert property (state == ST_CORE_GO |-> ##[1:400] state == ST_RAW_GO)
		else $error("update loop stalled");
endmodule : rdtc_top

// file: test/roll_diameter_and_taper_calc_tb.sv
// Self-checking bench of the roll diameter and taper calculator.
`timescale 1ns/1ps
`include "rdtc_cfg.svh"
module roll_diameter_and_taper_calc_tb
	import rdtc_pkg::*;
;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	rdtc_result_t calc_out;
	int errors = 0;
	int checked = 0;

	always #2.5 ref_clk = ~ref_clk;

	rdtc_top dut (.ref_clk(ref_clk), .srst(srst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .calc_out(calc_out));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Samples ready and data mid-cycle, so the edge that follows is the one
	// at which the phase completes.
	task automatic wait_rdy(output logic [31:0] d);
		int n;
		logic r;
		n = 0;
		r = 1'b0;
		d = 32'h0;
		while (r !== 1'b1 && n < 20) begin
			@(negedge ref_clk);
			r = hreadyout;
			d = hrdata;
			n++;
			@(posedge ref_clk);
		end
		chk({15'h0, r}, 16'h0001);
		chk({15'h0, hresp}, 16'h0000);
	endtask : wait_rdy

	task automatic bus(input logic wr, input logic [7:0] idx,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] d;
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= `RDTC_HSIZE_WORD;
		wait_rdy(d);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0, wd};
		wait_rdy(d);
		rd = d[15:0];
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [15:0] v);
		logic [15:0] x;
		bus(1'b1, idx, v, x);
	endtask : wr

	task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp);
		logic [15:0] x;
		bus(1'b0, idx, 16'h0, x);
		chk(x, exp);
	endtask : rd_chk

	// Results are only stable once a few computation passes have run.
	// Ends mid-cycle so results are read away from the edge that moves them.
	task automatic settle();
		repeat (800) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : settle

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] ia [11] = '{8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'hEA,
			8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hF8};
		logic [15:0] ea [11] = '{16'h0000, 16'h0064, 16'h03E8, 16'h0000,
			16'h0001, 16'h0000, 16'h00C8, 16'h0000, 16'h0000, 16'h0000,
			16'h0000};
		@(negedge ref_clk);
		chk(calc_out.size, 16'h0064);
		chk(calc_out.core_ratio, 16'h2710);
		chk(calc_out.full_ratio, 16'h03E8);
		chk(calc_out.demand, 16'h0000);
		for (int i = 0; i < 11; i++) begin
			rd_chk(ia[i], ea[i]);
		end
	endtask : t_reset

	task automatic t_off();
		wr(`RDTC_IDX_CORE, 16'h00C8);
		settle();
		chk(calc_out.size, 16'h00C8);
		chk(calc_out.core_ratio, 16'h2710);
		chk(calc_out.full_ratio, 16'h07D0);
		wr(`RDTC_IDX_SIZE, 16'h1234);
		rd_chk(`RDTC_IDX_SIZE, 16'h00C8);
		rd_chk(8'h10, 16'h0000);
	endtask : t_off

	// Ratio sweep with taper from 6.00 to 10.00 units, setpoint 50.00%.
	task automatic t_ext_taper();
		logic [15:0] ra [4] = '{16'h0000, 16'h1388, 16'h1D4C, 16'h2710};
		logic [15:0] sa [4] = '{16'h00C8, 16'h0258, 16'h0320, 16'h03E8};
		logic [15:0] da [4] = '{16'h1388, 16'h1388, 16'h1194, 16'h0FA0};
		wr(`RDTC_IDX_SETPOINT, 16'h1388);
		wr(`RDTC_IDX_TAPER, 16'h07D0);
		wr(`RDTC_IDX_TAPER_START, 16'h0258);
		wr(`RDTC_IDX_METHOD, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			wr(`RDTC_IDX_RATIO, ra[i]);
			settle();
			chk(calc_out.size, sa[i]);
			chk(calc_out.demand, da[i]);
			rd_chk(`RDTC_IDX_DEMAND, da[i]);
			if (i == 1) begin
				chk(calc_out.core_ratio, 16'h0D05);
				chk(calc_out.full_ratio, 16'h1770);
			end
		end
	endtask : t_ext_taper

	task automatic t_roll();
		logic [15:0] g;
		wr(`RDTC_IDX_METHOD, 16'h0002);
		wr(`RDTC_IDX_TURNS, 16'h000A);
		for (int p = 0; p < 4; p++) begin
			wr(8'(`RDTC_IDX_GAUGE0 + p), 16'(16'h000A * (p + 1)));
		end
		for (int p = 0; p < 4; p++) begin
			g = 16'(16'h000A * (p + 1));
			wr(`RDTC_IDX_PICK_HI, {15'h0, p[1]});
			wr(`RDTC_IDX_PICK_LO, {15'h0, p[0]});
			settle();
			chk(calc_out.size, 16'(16'h00C8 + 16'h0002 * g));
		end
		wr(`RDTC_IDX_KIND, 16'h0001);
		settle();
		chk(calc_out.size, 16'h0398);
	endtask : t_roll

	task automatic t_line();
		logic ok;
		wr(`RDTC_IDX_METHOD, 16'h0003);
		wr(`RDTC_IDX_KIND, 16'h0000);
		wr(`RDTC_IDX_PICK_HI, 16'h0000);
		wr(`RDTC_IDX_PICK_LO, 16'h0000);
		wr(`RDTC_IDX_LEN, 16'h03E8);
		wr(`RDTC_IDX_TURNS, 16'h0064);
		settle();
		ok = calc_out.size > 16'h00C8 && calc_out.size < 16'h03E8;
		chk({15'h0, ok}, 16'h0001);
		wr(`RDTC_IDX_TURNS, 16'h0000);
		settle();
		chk(calc_out.size, 16'h00C8);
	endtask : t_line

	// Freeze is raised before the line stops and cleared on restart.
	task automatic t_speed();
		wr(`RDTC_IDX_METHOD, 16'h0004);
		wr(`RDTC_IDX_REEL, 16'h03E8);
		wr(`RDTC_IDX_LINE, 16'h0BB8);
		settle();
		chk(calc_out.size, 16'h0258);
		wr(`RDTC_IDX_FREEZE, 16'h0001);
		wr(`RDTC_IDX_LINE, 16'h0000);
		settle();
		chk(calc_out.size, 16'h0258);
		wr(`RDTC_IDX_LINE, 16'h0FA0);
		wr(`RDTC_IDX_FREEZE, 16'h0000);
		settle();
		chk(calc_out.size, 16'h0320);
		wr(`RDTC_IDX_LINE, 16'h0064);
		settle();
		chk(calc_out.size, 16'h00C8);
	endtask : t_speed

	task automatic t_smooth();
		logic ok;
		wr(`RDTC_IDX_METHOD, 16'h0001);
		wr(`RDTC_IDX_RATIO, 16'h0000);
		settle();
		chk(calc_out.size, 16'h00C8);
		wr(`RDTC_IDX_SMOOTH, 16'h000F);
		wr(`RDTC_IDX_RATIO, 16'h2710);
		settle();
		ok = calc_out.size >= 16'h00C8 && calc_out.size < 16'h03E8;
		chk({15'h0, ok}, 16'h0001);
		wr(`RDTC_IDX_SMOOTH, 16'h0000);
		settle();
		chk(calc_out.size, 16'h03E8);
		// A method code past the last one must act as no calculation.
		wr(`RDTC_IDX_METHOD, 16'h0007);
		settle();
		chk(calc_out.size, 16'h00C8);
	endtask : t_smooth

	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize

	initial begin
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_off();
		t_ext_taper();
		t_roll();
		t_line();
		t_speed();
		t_smooth();
		summarize();
	end

	// The tests need about 16000 cycles; this allows about 40000.
	initial begin
		#200000;
		errors++;
		$display("BAD t=%0t watchdog expired", $time);
		summarize();
	end
endmodule : roll_diameter_and_taper_calc_tb
